// [verilog/ffctl_pkg.sv]
package ffctl_pkg;
  localparam int unsigned NUM_FF      = 21;
  localparam int unsigned LOW_FF      = 16;
  localparam int unsigned MUX_FF      = 4;
  localparam int unsigned MUX_BASE    = 16;
  localparam int unsigned LAST_FF     = 20;
  localparam int unsigned EVENT_LINES = 4;
  localparam int unsigned GUARD_H_LSB = 3;
  localparam int unsigned GUARD_H_TOP = 23;
  localparam int unsigned FIELD_W     = 2;

  // Printed offsets are register indices; byte address is four times that
  localparam logic [31:0] SOURCE_HIGH_IDX = 32'h0080_0223;
  localparam logic [31:0] GUARD_LOW_IDX   = 32'h0080_0224;
  localparam logic [31:0] FORCE_LOW_IDX   = 32'h0080_0226;
  localparam logic [31:0] GUARD_HIGH_IDX  = 32'h0080_0229;
  localparam logic [31:0] SOURCE_HIGH_ADDR = {SOURCE_HIGH_IDX[29:0], 2'h0};
  localparam logic [31:0] GUARD_LOW_ADDR   = {GUARD_LOW_IDX[29:0], 2'h0};
  localparam logic [31:0] FORCE_LOW_ADDR   = {FORCE_LOW_IDX[29:0], 2'h0};
  localparam logic [31:0] GUARD_HIGH_ADDR  = {GUARD_HIGH_IDX[29:0], 2'h0};

  localparam logic [15:0] GUARD_LOW_RST   = 16'h0000;
  localparam logic [15:0] FORCE_LOW_RST   = 16'h0000;
  localparam logic [7:0]  GUARD_HIGH_RST  = 8'h00;
  localparam logic [7:0]  SOURCE_HIGH_RST = 8'h00;
  localparam logic [7:0]  GUARD_HIGH_MASK = 8'hF8;
  localparam logic [20:0] LEVEL_RST       = 21'h000000;

  typedef logic [1:0] src_code_t;
  localparam src_code_t CODE_TIMER = 2'h0;
  localparam src_code_t CODE_ALT_A = 2'h1;
  localparam src_code_t CODE_ALT_B = 2'h2;
  localparam src_code_t CODE_ALT_C = 2'h3;
  localparam int unsigned EV_LINE0 = 0;
  localparam int unsigned EV_LINE1 = 1;
  localparam int unsigned EV_LINE3 = 3;
endpackage

// [verilog/regbus_if.sv]
`timescale 1ns/100ps
`default_nettype none
interface regbus_if;
  logic        wr_stb;
  logic        rd_stb;
  logic [31:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        hit;
  modport port (output wr_stb, rd_stb, addr, wdata, input rdata, hit);
  modport regs (input wr_stb, rd_stb, addr, wdata, output rdata, hit);
endinterface
`default_nettype wire

// [verilog/apb_word_port.sv]
`timescale 1ns/100ps
`default_nettype none
module apb_word_port (
  // Clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        reset_in,
  // APB slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [31:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // Register side
  regbus_if.port           rb
);
  logic access_w;
  logic first_w;

  // One wait state: data is read in the first access cycle, the write
  // lands on the edge where pready is sampled high.
  assign access_w  = psel_in & penable_in;
  assign first_w   = access_w & ~pready_out;
  assign rb.addr   = paddr_in;
  assign rb.wdata  = pwdata_in;
  assign rb.rd_stb = first_w & ~pwrite_in;
  assign rb.wr_stb = access_w & pready_out & pwrite_in & rb.hit;

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h0000_0000;
    end else begin
      pready_out  <= first_w;
      pslverr_out <= first_w & ~rb.hit;
      prdata_out  <= (first_w & ~pwrite_in & rb.hit) ? rb.rdata
                                                       : 32'h0000_0000;
    end
  end
endmodule
`default_nettype wire

// [verilog/source_pick.sv]
`timescale 1ns/100ps
`default_nettype none
module source_pick
  import ffctl_pkg::*;
#(
  parameter bit FOUR_WAY = 1'b0
) (
  // Selection
  input  wire src_code_t                  code_in,
  input  wire logic                       timer_pulse_in,
  input  wire logic [EVENT_LINES-1:0]     event_bus_in,
  output logic                            pick_out
);
  logic pick_four_w;
  logic pick_two_w;

  assign pick_four_w = (code_in == CODE_TIMER) ? timer_pulse_in :
                       (code_in == CODE_ALT_A) ? event_bus_in[EV_LINE0] :
                       (code_in == CODE_ALT_B) ? event_bus_in[EV_LINE1] :
                                                 event_bus_in[EV_LINE3];
  // Upper code bit clear means the timer, whatever the lower bit
  assign pick_two_w  = !code_in[1]              ? timer_pulse_in :
                       (code_in == CODE_ALT_B) ? event_bus_in[EV_LINE0] :
                                                 event_bus_in[EV_LINE1];
  assign pick_out    = FOUR_WAY ? pick_four_w : pick_two_w;
endmodule
`default_nettype wire

// [verilog/ff_output_ctrl.sv]
`timescale 1ns/100ps
`default_nettype none
module ff_output_ctrl
  import ffctl_pkg::*;
#(
  parameter int unsigned EVENT_W = EVENT_LINES
) (
  // Clock and reset
  input  wire logic                clk_sys_in,
  input  wire logic                reset_in,
  // APB slave
  input  wire logic                psel_in,
  input  wire logic                penable_in,
  input  wire logic                pwrite_in,
  input  wire logic [31:0]         paddr_in,
  input  wire logic [31:0]         pwdata_in,
  output logic      [31:0]         prdata_out,
  output logic                     pready_out,
  output logic                     pslverr_out,
  // Already-selected source pulses for flip-flops 0 to 15 and 20
  input  wire logic [LOW_FF-1:0]   low_src_pulse_in,
  input  wire logic                ff20_src_pulse_in,
  // Io timer channels 5 to 8 pulses, index 0 is channel 5
  input  wire logic [MUX_FF-1:0]   io_timer_pulse_in,
  // Internal output event bus
  input  wire logic [EVENT_W-1:0]  event_bus_in,
  // Flip-flop levels
  output logic      [NUM_FF-1:0]   ff_level_out
);
  if (EVENT_W < EVENT_LINES) begin : g_bad_event_w
    $error("event bus narrower than the source fields need");
  end

  regbus_if rb ();

  apb_word_port u_port (
    .clk_sys_in  (clk_sys_in),
    .reset_in    (reset_in),
    .psel_in     (psel_in),
    .penable_in  (penable_in),
    .pwrite_in   (pwrite_in),
    .paddr_in    (paddr_in),
    .pwdata_in   (pwdata_in),
    .prdata_out  (prdata_out),
    .pready_out  (pready_out),
    .pslverr_out (pslverr_out),
    .rb          (rb)
  );

  // Register state
  logic [15:0]       guard_low_r;
  logic [7:0]        guard_high_r;
  logic [7:0]        source_high_r;
  logic [NUM_FF-1:0] level_nxt;

  // Address decode
  logic hit_src_w;
  logic hit_guard_lo_w;
  logic hit_force_w;
  logic hit_guard_hi_w;
  logic wr_src_w;
  logic wr_guard_lo_w;
  logic wr_force_w;
  logic wr_guard_hi_w;

  assign hit_src_w      = (rb.addr == SOURCE_HIGH_ADDR);
  assign hit_guard_lo_w = (rb.addr == GUARD_LOW_ADDR);
  assign hit_force_w    = (rb.addr == FORCE_LOW_ADDR);
  assign hit_guard_hi_w = (rb.addr == GUARD_HIGH_ADDR);
  assign rb.hit         = hit_src_w | hit_guard_lo_w | hit_force_w
                        | hit_guard_hi_w;
  assign wr_src_w       = rb.wr_stb & hit_src_w;
  assign wr_guard_lo_w  = rb.wr_stb & hit_guard_lo_w;
  assign wr_force_w     = rb.wr_stb & hit_force_w;
  assign wr_guard_hi_w  = rb.wr_stb & hit_guard_hi_w;

  // Mirrored view of the low flip-flops, bit 0 is flip-flop 15
  logic [15:0] force_view_w;
  logic [NUM_FF-1:0] guard_w;

  genvar gi;
  generate
    for (gi = 0; gi < LOW_FF; gi++) begin : g_low_map
      assign force_view_w[gi]      = ff_level_out[LOW_FF-1-gi];
      assign guard_w[LOW_FF-1-gi]  = guard_low_r[gi];
    end
    for (gi = MUX_BASE; gi < NUM_FF; gi++) begin : g_high_map
      assign guard_w[gi] = guard_high_r[GUARD_H_TOP-gi];
    end
  endgenerate

  assign rb.rdata = hit_src_w      ? {24'h000000, source_high_r} :
                    hit_guard_lo_w ? {16'h0000, guard_low_r}     :
                    hit_force_w    ? {16'h0000, force_view_w}    :
                    hit_guard_hi_w ? {24'h000000, guard_high_r}  :
                                     32'h0000_0000;

  // Guard and source registers; plain word writes, halfword use by
  // software keeps the upper lanes at zero anyway.
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      guard_low_r   <= GUARD_LOW_RST;
      guard_high_r  <= GUARD_HIGH_RST;
      source_high_r <= SOURCE_HIGH_RST;
    end else begin
      if (wr_guard_lo_w) begin
        guard_low_r <= rb.wdata[15:0];
      end
      if (wr_guard_hi_w) begin
        guard_high_r <= rb.wdata[7:0] & GUARD_HIGH_MASK;
      end
      if (wr_src_w) begin
        source_high_r <= rb.wdata[7:0];
      end
    end
  end

  // Source selection for flip-flops 16 to 19; flip-flop 19 uses bits 1:0
  logic [NUM_FF-1:0] pulse_w;
  logic [MUX_FF-1:0] mux_pick_w;

  generate
    for (gi = 0; gi < MUX_FF; gi++) begin : g_mux
      localparam int unsigned FLD = MUX_FF-1-gi;
      source_pick #(
        .FOUR_WAY (gi == 0)
      ) u_pick (
        .code_in        (source_high_r[FIELD_W*FLD +: FIELD_W]),
        .timer_pulse_in (io_timer_pulse_in[gi]),
        .event_bus_in   (event_bus_in[EVENT_LINES-1:0]),
        .pick_out       (mux_pick_w[gi])
      );
      assign pulse_w[MUX_BASE+gi] = mux_pick_w[gi];
    end
  endgenerate

  assign pulse_w[LOW_FF-1:0] = low_src_pulse_in;
  assign pulse_w[LAST_FF]    = ff20_src_pulse_in;

  // Next level: an unguarded forced write wins over a toggle in the
  // same cycle, since software asked for an absolute level.
  generate
    for (gi = 0; gi < NUM_FF; gi++) begin : g_level
      if (gi < LOW_FF) begin : g_forceable
        logic load_w;
        assign load_w = wr_force_w & ~guard_w[gi];
        assign level_nxt[gi] = load_w ? rb.wdata[LOW_FF-1-gi]
                             : (ff_level_out[gi] ^ pulse_w[gi]);
      end else begin : g_toggle_only
        assign level_nxt[gi] = ff_level_out[gi] ^ pulse_w[gi];
      end
    end
  endgenerate

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      ff_level_out <= LEVEL_RST;
    end else begin
      ff_level_out <= level_nxt;
    end
  end

  // Bit reversal of the low flip-flops, so the checks need no streaming cast
  function automatic logic [15:0] mirror16(input logic [15:0] v);
    logic [15:0] r;
    for (int i = 0; i < LOW_FF; i++) begin
      r[i] = v[LOW_FF-1-i];
    end
    return r;
  endfunction

  // Checks
  chk_src19_timer: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    (!source_high_r[1] && io_timer_pulse_in[3])
      |=> ff_level_out[19] != $past(ff_level_out[19]))
    else $error("flip-flop 19 missed its timer pulse");

  chk_src19_bus1: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    (source_high_r[1:0] == CODE_ALT_C && !event_bus_in[EV_LINE1])
      |=> ff_level_out[19] == $past(ff_level_out[19]))
    else $error("flip-flop 19 moved without bus line 1");

  chk_src18_bus0: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    (source_high_r[3:2] == CODE_ALT_B && event_bus_in[EV_LINE0])
      |=> ff_level_out[18] != $past(ff_level_out[18]))
    else $error("flip-flop 18 missed bus line 0");

  chk_src17_bus1: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    (source_high_r[5:4] == CODE_ALT_C && event_bus_in[EV_LINE1])
      |=> ff_level_out[17] != $past(ff_level_out[17]))
    else $error("flip-flop 17 missed bus line 1");

  chk_src16_bus3: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    (source_high_r[7:6] == CODE_ALT_C)
      |=> ff_level_out[16] ==
          ($past(ff_level_out[16]) ^ $past(event_bus_in[EV_LINE3])))
    else $error("flip-flop 16 not following bus line 3");

  chk_src16_timer: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    (source_high_r[7:6] == CODE_TIMER)
      |=> ff_level_out[16] ==
          ($past(ff_level_out[16]) ^ $past(io_timer_pulse_in[0])))
    else $error("flip-flop 16 not following io timer 5");

  chk_quiet_hold: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    (!ff20_src_pulse_in) |=> $stable(ff_level_out[20]))
    else $error("flip-flop 20 moved without a pulse");

  chk_pulse_toggle: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    ff20_src_pulse_in ##1 ff20_src_pulse_in
      |=> ff_level_out[20] == $past(ff_level_out[20], 2))
    else $error("two pulses did not cancel on flip-flop 20");

  chk_guard_blocks: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    (wr_force_w && guard_low_r[0] && !low_src_pulse_in[15])
      |=> $stable(ff_level_out[15]))
    else $error("guarded flip-flop 15 took a write");

  chk_force_loads: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    (wr_force_w && !guard_low_r[15])
      |=> ff_level_out[0] == $past(pwdata_in[15]))
    else $error("unguarded flip-flop 0 ignored a write");

  chk_force_view: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    (rb.rd_stb && hit_force_w)
      |=> prdata_out[15:0] == mirror16($past(ff_level_out[15:0])))
    else $error("force value word not mirrored");

  chk_ready_pulse: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    pready_out |=> !pready_out)
    else $error("pready held for more than one cycle");

  chk_src19_bus0: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    (source_high_r[1:0] == CODE_ALT_B && event_bus_in[EV_LINE0])
      |=> ff_level_out[19] != $past(ff_level_out[19]))
    else $error("flip-flop 19 missed bus line 0");

  chk_src19_idle: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    (source_high_r[1:0] == CODE_ALT_B && !event_bus_in[EV_LINE0])
      |=> $stable(ff_level_out[19]))
    else $error("flip-flop 19 moved from an unselected source");

  chk_src18_timer: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    (!source_high_r[3] && io_timer_pulse_in[2])
      |=> ff_level_out[18] != $past(ff_level_out[18]))
    else $error("flip-flop 18 missed its timer pulse");

  chk_src18_bus1: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    (source_high_r[3:2] == CODE_ALT_C && event_bus_in[EV_LINE1])
      |=> ff_level_out[18] != $past(ff_level_out[18]))
    else $error("flip-flop 18 missed bus line 1");

  chk_src17_timer: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    (!source_high_r[5] && io_timer_pulse_in[1])
      |=> ff_level_out[17] != $past(ff_level_out[17]))
    else $error("flip-flop 17 missed its timer pulse");

  chk_src17_bus0: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    (source_high_r[5:4] == CODE_ALT_B && event_bus_in[EV_LINE0])
      |=> ff_level_out[17] != $past(ff_level_out[17]))
    else $error("flip-flop 17 missed bus line 0");

  chk_src16_bus0: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    (source_high_r[7:6] == CODE_ALT_A)
      |=> ff_level_out[16] ==
          ($past(ff_level_out[16]) ^ $past(event_bus_in[EV_LINE0])))
    else $error("flip-flop 16 not following bus line 0");

  chk_src16_bus1: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    (source_high_r[7:6] == CODE_ALT_B)
      |=> ff_level_out[16] ==
          ($past(ff_level_out[16]) ^ $past(event_bus_in[EV_LINE1])))
    else $error("flip-flop 16 not following bus line 1");

  chk_guard_lo_write: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    wr_guard_lo_w |=> guard_low_r == $past(pwdata_in[15:0]))
    else $error("low guard word did not take the write");

  chk_guard_hi_write: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    wr_guard_hi_w
      |=> guard_high_r[7:3] == $past(pwdata_in[7:3])
          && guard_high_r[2:0] == 3'h0)
    else $error("high guard word did not take the write");

  chk_guard_blocks_mid: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    (wr_force_w && guard_low_r[7] && !low_src_pulse_in[8])
      |=> $stable(ff_level_out[8]))
    else $error("guarded flip-flop 8 took a write");

  chk_force_mirror_lsb: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    (wr_force_w && !guard_low_r[0])
      |=> ff_level_out[15] == $past(pwdata_in[0]))
    else $error("force value bit 0 did not load flip-flop 15");

  chk_low_toggle: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    (!wr_force_w && low_src_pulse_in[15])
      |=> ff_level_out[15] != $past(ff_level_out[15]))
    else $error("flip-flop 15 missed its pulse");

  chk_low_quiet: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    (!wr_force_w && !low_src_pulse_in[0])
      |=> $stable(ff_level_out[0]))
    else $error("flip-flop 0 moved without a pulse or write");

  chk_ff20_toggle: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    ff20_src_pulse_in |=> ff_level_out[20] != $past(ff_level_out[20]))
    else $error("flip-flop 20 missed its pulse");

  chk_ready_after_access: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    (psel_in && penable_in && !pready_out) |=> pready_out)
    else $error("no ready one cycle after the access began");

  chk_err_with_ready: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    pslverr_out |-> pready_out)
    else $error("slave error without ready");

  chk_rdata_idle: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    !pready_out |-> prdata_out == 32'h0000_0000)
    else $error("read data not zero outside the answer cycle");
endmodule
`default_nettype wire

// [test/timer_pulse_model.sv]
`timescale 1ns/100ps
`default_nettype none
module timer_pulse_model (
  // Clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       reset_in,
  // Commands from the bench
  input  wire logic [3:0] start_in,
  input  wire logic [3:0] event_in,
  // Pulses toward the block
  output logic      [3:0] timer_pulse_out,
  output logic      [3:0] event_out
);
  // Short reload keeps both edges of a single shot inside one check
  localparam logic [3:0] RELOAD = 4'h3;
  logic [3:0] cnt_r [4];

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      timer_pulse_out <= 4'h0;
      event_out <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        cnt_r[i] <= 4'h0;
      end
    end else begin
      event_out <= event_in;
      for (int i = 0; i < 4; i++) begin
        if (start_in[i]) begin
          cnt_r[i] <= RELOAD;
          timer_pulse_out[i] <= 1'b1;
        end else begin
          cnt_r[i] <= (cnt_r[i] != 4'h0) ? cnt_r[i] - 4'h1 : 4'h0;
          timer_pulse_out[i] <= (cnt_r[i] == 4'h1);
        end
      end
    end
  end
endmodule
`default_nettype wire

// [test/timer_output_flipflop_control_bench.sv]
`timescale 1ns/100ps
`default_nettype none
module timer_output_flipflop_control_bench;
  import ffctl_pkg::*;
  logic        clk_sys_in = 1'b0;
  logic        reset_in   = 1'b1;
  logic        psel       = 1'b0;
  logic        penable    = 1'b0;
  logic        pwrite     = 1'b0;
  logic [31:0] paddr      = 32'h0;
  logic [31:0] pwdata     = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [15:0] low_pulse  = 16'h0;
  logic        ff20_pulse = 1'b0;
  logic [3:0]  start      = 4'h0;
  logic [3:0]  ev         = 4'h0;
  logic [3:0]  tmr_p;
  logic [3:0]  ev_p;
  logic [20:0] lvl;
  logic [20:0] exp_lvl    = 21'h0;
  int          num_errors = 0;
  int          n_compared = 0;

  always #50 clk_sys_in = ~clk_sys_in;

  ff_output_ctrl dut (
    .clk_sys_in(clk_sys_in), .reset_in(reset_in),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr),
    .low_src_pulse_in(low_pulse), .ff20_src_pulse_in(ff20_pulse),
    .io_timer_pulse_in(tmr_p), .event_bus_in(ev_p), .ff_level_out(lvl)
  );

  timer_pulse_model model (
    .clk_sys_in(clk_sys_in), .reset_in(reset_in), .start_in(start),
    .event_in(ev), .timer_pulse_out(tmr_p), .event_out(ev_p)
  );

  task automatic fail(input string msg);
    num_errors++;
    $display("Error at %0t: %s", $time, msg);
  endtask

  task automatic chk_lvl(input string msg);
    n_compared++;
    if (lvl !== exp_lvl) fail(msg);
  endtask

  task automatic print_verdict;
    if (num_errors == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // One whole word per transfer; the bus carries no access size
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     input logic [31:0] exp_d, input logic exp_e);
    @(posedge clk_sys_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_in);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys_in);
    end while (pready !== 1'b1);
    n_compared++;
    if (pready !== 1'b1 || pslverr !== exp_e || (!w && prdata !== exp_d))
      fail($sformatf("bus access at %h", a));
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Source index: 0..3 io timer of flip-flop 16+k, 4..7 event lines 0..3
  function automatic int pick(input int k, input int code);
    if (k == 0) return (code == 0) ? 0 : (code == 3) ? 7 : code + 3;
    return (code < 2) ? k : code + 2;
  endfunction

  task automatic fire(input int s, input int c);
    logic [20:0] m;
    m = '0;
    for (int k = 0; k < 4; k++) begin
      if (pick(k, (c + k) % 4) == s) m[16+k] = 1'b1;
    end
    @(posedge clk_sys_in);
    if (s < 4) start[s] <= 1'b1;
    else ev[s-4] <= 1'b1;
    @(posedge clk_sys_in);
    start <= 4'h0;
    ev <= 4'h0;
    repeat (2) @(negedge clk_sys_in);
    exp_lvl ^= m;
    chk_lvl("toggle on selected source");
    if (s < 4) begin
      repeat (3) @(negedge clk_sys_in);
      exp_lvl ^= m;
      chk_lvl("toggle on underflow");
    end
  endtask

  task automatic t_reset;
    apb(1'b0, SOURCE_HIGH_ADDR, 32'h0, 32'h0, 1'b0);
    apb(1'b0, GUARD_LOW_ADDR, 32'h0, 32'h0, 1'b0);
    apb(1'b0, FORCE_LOW_ADDR, 32'h0, 32'h0, 1'b0);
    apb(1'b0, GUARD_HIGH_ADDR, 32'h0, 32'h0, 1'b0);
    apb(1'b0, 32'h0000_0100, 32'h0, 32'h0, 1'b1);
    chk_lvl("level after reset");
  endtask

  task automatic t_sources;
    logic [7:0] r;
    for (int c = 0; c < 4; c++) begin
      r = '0;
      for (int k = 0; k < 4; k++) r[2*(3-k) +: 2] = 2'((c + k) % 4);
      apb(1'b1, SOURCE_HIGH_ADDR, {24'h0, r}, 32'h0, 1'b0);
      apb(1'b0, SOURCE_HIGH_ADDR, 32'h0, {24'h0, r}, 1'b0);
      for (int s = 0; s < 8; s++) fire(s, c);
    end
  endtask

  task automatic t_guard_force;
    apb(1'b1, GUARD_LOW_ADDR, 32'h0000_00FF, 32'h0, 1'b0);
    apb(1'b1, FORCE_LOW_ADDR, 32'h0000_FFFF, 32'h0, 1'b0);
    repeat (2) @(negedge clk_sys_in);
    exp_lvl[15:0] = 16'h00FF;
    chk_lvl("guarded force write");
    apb(1'b0, FORCE_LOW_ADDR, 32'h0, 32'h0000_FF00, 1'b0);
    apb(1'b0, GUARD_LOW_ADDR, 32'h0, 32'h0000_00FF, 1'b0);
    apb(1'b1, GUARD_LOW_ADDR, 32'h0, 32'h0, 1'b0);
    apb(1'b1, FORCE_LOW_ADDR, 32'h0000_0001, 32'h0, 1'b0);
    repeat (2) @(negedge clk_sys_in);
    exp_lvl[15:0] = 16'h8000;
    chk_lvl("mirrored force write");
    apb(1'b1, GUARD_HIGH_ADDR, 32'h0000_00FF, 32'h0, 1'b0);
    apb(1'b0, GUARD_HIGH_ADDR, 32'h0, 32'h0000_00F8, 1'b0);
  endtask

  task automatic t_pulses;
    @(posedge clk_sys_in);
    low_pulse <= 16'h8001;
    ff20_pulse <= 1'b1;
    @(posedge clk_sys_in);
    low_pulse <= 16'h0;
    ff20_pulse <= 1'b0;
    repeat (2) @(negedge clk_sys_in);
    exp_lvl ^= 21'h108001;
    chk_lvl("preselected pulses");
    @(posedge clk_sys_in);
    ff20_pulse <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    ff20_pulse <= 1'b0;
    @(negedge clk_sys_in);
    chk_lvl("two pulses did not cancel");
  endtask

  initial begin
    repeat (10) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    t_reset();
    t_sources();
    t_guard_force();
    t_pulses();
    print_verdict();
  end

  initial begin
    #2000000;
    fail("timeout");
    print_verdict();
  end
endmodule
`default_nettype wire
